// ---- logic/usc_system_config.sv ----
// Purpose: System configuration and line status registers of a USB
//          host/peripheral controller.
// Assumes: Inputs synchronous to core_clk; strobes one cycle long.
// Notes:   Read data stands in the cycle after the read strobe only.
`timescale 1ns/1ps

module usc_system_config
  import usc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic              wakeReq,
  input  wire logic              handshakeDone,
  input  wire logic              handshakeHighSpeed,
  input  wire logic [1:0]        lineRaw,
  output logic      [1:0]        inputClockSelect,
  output logic                   oscBufferEnable,
  output logic                   referenceClockEnable,
  output logic                   pllEnable,
  output logic                   internalClockEnable,
  output logic                   highSpeedEnable,
  output logic                   hostRole,
  output logic                   linkHighSpeed,
  output logic                   dplusPullupEn,
  output logic                   dplusPulldownEn,
  output logic                   dminusPulldownEn,
  output logic                   fsReceiverOn,
  output logic                   sleepActive,
  output logic                   blockReset_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register state.

  logic [1:0] clkSel_q;
  logic       oscBuf_q;
  logic       refClk_q;
  logic       pll_q;
  logic       intClk_q;
  logic       autoClk_q;
  logic       hsEn_q;
  logic       role_q;
  logic       dmPd_q;
  logic       dpPu_q;
  logic       fsForce_q;
  logic       blockEn_q;
  usc_power_t power_q;
  logic       speedHs_q;
  logic [1:0] lineState_q;
  logic [DATA_W-1:0] regRdata_q;

  logic cfgWr;
  logic wakeExit;
  logic clkStopWake;

  assign cfgWr = regWr && (regAddr == OFS_SYSTEM_CONFIGURATION);

  // Sleep is left on a wake request; a stopped clock restarts only
  // when auto clock supply is enabled.
  assign wakeExit    = (power_q == USC_SLEEP) && wakeReq;
  assign clkStopWake = (power_q == USC_RUN) && !intClk_q && autoClk_q &&
                       wakeReq;

  function automatic logic [DATA_W-1:0] cfgImage();
    logic [DATA_W-1:0] img;
    img = '0;
    img[BIT_CLKSEL_HI:BIT_CLKSEL_LO] = clkSel_q;
    img[BIT_OSC_BUF]     = oscBuf_q;
    img[BIT_REF_CLK]     = refClk_q;
    img[BIT_PLL]         = pll_q;
    img[BIT_INT_CLK]     = intClk_q;
    img[BIT_AUTO_CLK]    = autoClk_q;
    img[BIT_HS_EN]       = hsEn_q;
    img[BIT_ROLE]        = role_q;
    img[BIT_DM_PULLDOWN] = dmPd_q;
    img[BIT_DP_PULLUP]   = dpPu_q;
    img[BIT_FS_FORCE]    = fsForce_q;
    img[BIT_SLEEP]       = (power_q == USC_SLEEP);
    img[BIT_BLOCK_EN]    = blockEn_q;
    return img;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Plain software fields.

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clkSel_q  <= RST_SYSTEM_CONFIGURATION[BIT_CLKSEL_HI:BIT_CLKSEL_LO];
      autoClk_q <= RST_SYSTEM_CONFIGURATION[BIT_AUTO_CLK];
      hsEn_q    <= RST_SYSTEM_CONFIGURATION[BIT_HS_EN];
      role_q    <= RST_SYSTEM_CONFIGURATION[BIT_ROLE];
      dmPd_q    <= RST_SYSTEM_CONFIGURATION[BIT_DM_PULLDOWN];
      dpPu_q    <= RST_SYSTEM_CONFIGURATION[BIT_DP_PULLUP];
      fsForce_q <= RST_SYSTEM_CONFIGURATION[BIT_FS_FORCE];
      blockEn_q <= RST_SYSTEM_CONFIGURATION[BIT_BLOCK_EN];
    end else if (cfgWr) begin
      clkSel_q  <= regWdata[BIT_CLKSEL_HI:BIT_CLKSEL_LO];
      autoClk_q <= regWdata[BIT_AUTO_CLK];
      hsEn_q    <= regWdata[BIT_HS_EN];
      role_q    <= regWdata[BIT_ROLE];
      dmPd_q    <= regWdata[BIT_DM_PULLDOWN];
      dpPu_q    <= regWdata[BIT_DP_PULLUP];
      fsForce_q <= regWdata[BIT_FS_FORCE];
      blockEn_q <= regWdata[BIT_BLOCK_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock enables; hardware restarts win over a write in the same cycle.

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      oscBuf_q <= RST_SYSTEM_CONFIGURATION[BIT_OSC_BUF];
    end else if (wakeExit || clkStopWake) begin
      oscBuf_q <= 1'h1;
    end else if (cfgWr) begin
      oscBuf_q <= regWdata[BIT_OSC_BUF];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      refClk_q <= RST_SYSTEM_CONFIGURATION[BIT_REF_CLK];
      pll_q    <= RST_SYSTEM_CONFIGURATION[BIT_PLL];
      intClk_q <= RST_SYSTEM_CONFIGURATION[BIT_INT_CLK];
    end else if (autoClk_q && (wakeExit || clkStopWake)) begin
      refClk_q <= 1'h1;
      pll_q    <= 1'h1;
      intClk_q <= 1'h1;
    end else if (wakeExit) begin
      refClk_q <= 1'h0;
      pll_q    <= 1'h0;
      intClk_q <= 1'h0;
    end else if (cfgWr) begin
      refClk_q <= regWdata[BIT_REF_CLK];
      pll_q    <= regWdata[BIT_PLL];
      intClk_q <= regWdata[BIT_INT_CLK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power sleep; a software entry in the exit cycle wins.

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      power_q <= USC_RUN;
    end else begin
      case (power_q)
        USC_RUN: begin
          if (cfgWr && regWdata[BIT_SLEEP]) begin
            power_q <= USC_SLEEP;
          end
        end
        USC_SLEEP: begin
          if (wakeExit && !(cfgWr && regWdata[BIT_SLEEP])) begin
            power_q <= USC_RUN;
          end
        end
        default: power_q <= USC_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed outcome and line state, both under software reset.

  always_ff @(posedge core_clk) begin
    if (!rst_n || !blockEn_q) begin
      speedHs_q <= 1'h0;
    end else if (!hsEn_q) begin
      speedHs_q <= 1'h0;
    end else if (handshakeDone) begin
      speedHs_q <= handshakeHighSpeed;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !blockEn_q) begin
      lineState_q <= RST_LINE_STATE;
    end else if (fsReceiverOn) begin
      lineState_q <= lineRaw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port; unmapped addresses read zero.

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regRdata_q <= '0;
    end else if (regRd) begin
      case (regAddr)
        OFS_SYSTEM_CONFIGURATION: regRdata_q <= cfgImage();
        OFS_SYSTEM_LINE_STATUS:   regRdata_q <= {14'h0000, lineState_q};
        default:                  regRdata_q <= '0;
      endcase
    end else begin
      regRdata_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign regRdata             = regRdata_q;
  assign inputClockSelect     = clkSel_q;
  assign oscBufferEnable      = oscBuf_q;
  assign referenceClockEnable = refClk_q;
  assign pllEnable            = pll_q;
  assign internalClockEnable  = intClk_q;
  assign highSpeedEnable      = hsEn_q;
  assign hostRole             = role_q;
  assign linkHighSpeed        = hsEn_q && speedHs_q;
  assign dplusPullupEn        = dpPu_q;
  assign dplusPulldownEn      = dmPd_q && !dpPu_q;
  assign dminusPulldownEn     = dmPd_q;
  assign sleepActive          = (power_q == USC_SLEEP);
  assign blockReset_n         = blockEn_q;
  // The receiver is off in sleep unless software forces it on.
  assign fsReceiverOn = fsForce_q || (intClk_q && !sleepActive);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_clksel_write: assert property (
    cfgWr |=> inputClockSelect == $past(regWdata[15:14]))
    else $error("input clock select not written");

  a_osc_on_wake: assert property (
    wakeExit |=> oscBufferEnable)
    else $error("oscillator buffer not set on wake");

  a_auto_restart: assert property (
    (wakeExit || clkStopWake) && autoClk_q |=>
      internalClockEnable && pllEnable && referenceClockEnable)
    else $error("auto clock supply did not restart clocks");

  a_no_auto_stop: assert property (
    !autoClk_q && !sleepActive && !cfgWr |=> $stable(internalClockEnable))
    else $error("internal clock changed without software");

  a_fs_only: assert property (
    !highSpeedEnable |-> !linkHighSpeed)
    else $error("high speed without enable");

  a_hs_outcome: assert property (
    blockEn_q && hsEn_q && handshakeDone && !cfgWr |=>
      linkHighSpeed == $past(handshakeHighSpeed))
    else $error("speed does not follow handshake");

  a_sleep_entry: assert property (
    cfgWr && regWdata[1] |=> sleepActive)
    else $error("sleep not entered");

  a_sleep_exit: assert property (
    wakeExit && !(cfgWr && regWdata[BIT_SLEEP]) |=> !sleepActive)
    else $error("sleep bit not cleared");

  a_reset_hold: assert property (
    !blockEn_q |=> lineState_q == RST_LINE_STATE && !linkHighSpeed)
    else $error("software reset not holding state");

  a_status_zero: assert property (
    $past(regRd) && $past(regAddr) == OFS_SYSTEM_LINE_STATUS |->
      regRdata[15:2] == 14'h0000)
    else $error("status high bits not zero");

  a_line_sample: assert property (
    blockEn_q && fsReceiverOn |=> lineState_q == $past(lineRaw))
    else $error("line state not sampled");

  a_pull_host: assert property (
    dmPd_q && !dpPu_q |-> dplusPulldownEn && dminusPulldownEn &&
      !dplusPullupEn)
    else $error("host pull code wrong");

  a_rx_force: assert property (
    fsForce_q |-> fsReceiverOn)
    else $error("forced receiver not on");

  a_clk_write: assert property (
    cfgWr && !wakeExit && !clkStopWake |=>
      referenceClockEnable == $past(regWdata[BIT_REF_CLK]) &&
      pllEnable == $past(regWdata[BIT_PLL]) &&
      internalClockEnable == $past(regWdata[BIT_INT_CLK]))
    else $error("clock enable not written");

  a_clk_clear: assert property (
    wakeExit && !autoClk_q |=>
      !referenceClockEnable && !pllEnable && !internalClockEnable)
    else $error("clocks not stopped without auto supply");

  a_speed_role: assert property (
    cfgWr |=> highSpeedEnable == $past(regWdata[BIT_HS_EN]) &&
      hostRole == $past(regWdata[BIT_ROLE]))
    else $error("speed or role not written");

  a_block_write: assert property (
    cfgWr |=> blockReset_n == $past(regWdata[BIT_BLOCK_EN]))
    else $error("block enable not written");

  a_sleep_hold: assert property (
    sleepActive && !wakeReq |=> sleepActive)
    else $error("sleep left without wake");

  a_sleep_readback: assert property (
    $past(regRd) && $past(regAddr) == OFS_SYSTEM_CONFIGURATION |->
      regRdata[BIT_SLEEP] == $past(sleepActive))
    else $error("sleep bit does not read back state");

  a_cfg_unused: assert property (
    $past(regRd) && $past(regAddr) == OFS_SYSTEM_CONFIGURATION |->
      !regRdata[9] && !regRdata[3])
    else $error("unimplemented config bits not zero");

  a_rx_sleep_off: assert property (
    sleepActive && !fsForce_q |-> !fsReceiverOn)
    else $error("receiver on in sleep");

  a_line_hold: assert property (
    blockEn_q && !fsReceiverOn |=> $stable(lineState_q))
    else $error("line state moved with receiver off");

  c_sleep_wake: cover property (sleepActive ##[1:20] !sleepActive);
  c_hs_link: cover property (handshakeDone && linkHighSpeed);
  c_auto_stop: cover property (clkStopWake);
  c_status_read: cover property (regRd && regAddr == OFS_SYSTEM_LINE_STATUS);

endmodule

// ---- logic/usc_pkg.sv ----
// Purpose: Shared constants of the USB system configuration register bank.
// Assumes: Sixteen-bit registers on a plain strobe port.
// Notes:   Offsets are byte addresses of the register port.
package usc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  localparam logic [7:0] OFS_SYSTEM_CONFIGURATION = 8'h00;
  localparam logic [7:0] OFS_SYSTEM_LINE_STATUS   = 8'h02;

  // Field positions of the configuration register.
  localparam int unsigned BIT_CLKSEL_HI   = 15;
  localparam int unsigned BIT_CLKSEL_LO   = 14;
  localparam int unsigned BIT_OSC_BUF     = 13;
  localparam int unsigned BIT_REF_CLK     = 12;
  localparam int unsigned BIT_PLL         = 11;
  localparam int unsigned BIT_INT_CLK     = 10;
  localparam int unsigned BIT_AUTO_CLK    = 8;
  localparam int unsigned BIT_HS_EN       = 7;
  localparam int unsigned BIT_ROLE        = 6;
  localparam int unsigned BIT_DM_PULLDOWN = 5;
  localparam int unsigned BIT_DP_PULLUP   = 4;
  localparam int unsigned BIT_FS_FORCE    = 2;
  localparam int unsigned BIT_SLEEP       = 1;
  localparam int unsigned BIT_BLOCK_EN    = 0;

  // Reset values.
  localparam logic [15:0] RST_SYSTEM_CONFIGURATION = 16'h0000;
  localparam logic [1:0]  RST_LINE_STATE           = 2'h0;

  // Input clock selection codes.
  localparam logic [1:0] CLKSEL_12MHZ    = 2'h0;
  localparam logic [1:0] CLKSEL_24MHZ    = 2'h1;
  localparam logic [1:0] CLKSEL_48MHZ    = 2'h2;
  localparam logic [1:0] CLKSEL_RESERVED = 2'h3;

  // Full-Speed line state codes.
  localparam logic [1:0] LINE_SE0 = 2'h0;
  localparam logic [1:0] LINE_J   = 2'h1;
  localparam logic [1:0] LINE_K   = 2'h2;
  localparam logic [1:0] LINE_SE1 = 2'h3;

  // Sleep state machine.
  typedef enum logic {
    USC_RUN   = 1'h0,
    USC_SLEEP = 1'h1
  } usc_power_t;

endpackage

// ---- dv/usc_bus_model.sv ----
// Purpose: Behavioural model of the USB line and reset handshake side.
// Assumes: The bench sets the wanted line code and handshake outcome.
// Notes:   The speed result is only meaningful beside the done pulse.
`timescale 1ns/1ps

module usc_bus_model (
  input  wire logic       core_clk,
  input  wire logic [1:0] lineSet,
  input  wire logic       hsGo,
  input  wire logic       hsFast,
  output logic      [1:0] lineRaw,
  output logic            handshakeDone,
  output logic            handshakeHighSpeed
);
  always_ff @(posedge core_clk) begin
    lineRaw <= lineSet;
  end

  // Outside the done pulse the result shows the inverse of the last one.
  always_ff @(posedge core_clk) begin
    handshakeDone      <= hsGo;
    handshakeHighSpeed <= hsGo ? hsFast : ~hsFast;
  end
endmodule

// ---- dv/tb_usb_system_config_control.sv ----
// Purpose: Self-checking bench of the system configuration registers.
// Assumes: Register strobes are one cycle long.
// Notes:   Read results are queued and checked by a monitor.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin nCompared++; if ((s) !== (e)) begin \
  mismatches++; $display("Error %s exp %h got %h", nm, e, s); end end

module tb_usb_system_config_control import usc_pkg::*; ;
  logic              core_clk = 1'h0;
  logic              rst_n    = 1'h0;
  logic [ADDR_W-1:0] regAddr  = 8'h00;
  logic [DATA_W-1:0] regWdata = 16'h0000;
  logic [DATA_W-1:0] regRdata;
  logic              regWr = 1'h0, regRd = 1'h0, wakeReq = 1'h0;
  logic              hsGo = 1'h0, hsFast = 1'h0, rdPend = 1'h0;
  logic [1:0]        lineSet = 2'h0, lineRaw, inputClockSelect;
  logic              handshakeDone, handshakeHighSpeed, oscBufferEnable;
  logic              referenceClockEnable, pllEnable, internalClockEnable;
  logic              highSpeedEnable, hostRole, linkHighSpeed;
  logic              dplusPullupEn, dplusPulldownEn, dminusPulldownEn;
  logic              fsReceiverOn, sleepActive, blockReset_n;
  logic [15:0]       expQ[$];
  int                mismatches = 0;
  int                nCompared  = 0;
  wire logic [3:0]   clkEn = {oscBufferEnable, referenceClockEnable,
                              pllEnable, internalClockEnable};
  wire logic [2:0]   pulls = {dminusPulldownEn, dplusPulldownEn,
                              dplusPullupEn};

  usc_system_config usc_system_config_i (.core_clk, .rst_n, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .wakeReq, .handshakeDone,
    .handshakeHighSpeed, .lineRaw, .inputClockSelect, .oscBufferEnable,
    .referenceClockEnable, .pllEnable, .internalClockEnable,
    .highSpeedEnable, .hostRole, .linkHighSpeed, .dplusPullupEn,
    .dplusPulldownEn, .dminusPulldownEn, .fsReceiverOn, .sleepActive,
    .blockReset_n);

  usc_bus_model usc_bus_model_i (.core_clk, .lineSet, .hsGo, .hsFast,
    .lineRaw, .handshakeDone, .handshakeHighSpeed);

  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic close_out;
    $display("compared %0d mismatches %0d", nCompared, mismatches);
    if (mismatches == 0 && nCompared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regRd <= 1'h1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge core_clk);
    regRd <= 1'h0;
  endtask

  task automatic wake;
    @(posedge core_clk);
    wakeReq <= 1'h1;
    @(posedge core_clk);
    wakeReq <= 1'h0;
    #1;
  endtask

  task automatic hshake(input logic f);
    @(posedge core_clk);
    hsGo <= 1'h1;
    hsFast <= f;
    @(posedge core_clk);
    hsGo <= 1'h0;
    @(posedge core_clk);
    #1;
  endtask

  // Read data stands only in the cycle after the strobe.
  always @(posedge core_clk) begin
    if (rdPend) begin
      `CHK("read data", expQ[0], regRdata)
      void'(expQ.pop_front());
    end
    rdPend <= regRd;
  end

  initial begin
    repeat (2000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  ////////////////////////////////////////
  initial begin
    logic [15:0] v;
    v = 16'h0b48;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    rd(OFS_SYSTEM_CONFIGURATION, RST_SYSTEM_CONFIGURATION);
    rd(OFS_SYSTEM_LINE_STATUS, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      v = lfsr(v);
      v[15:14] = i[1:0];
      v[5:4] = i[2:1];
      v[9] = 1'h0;
      v[1] = 1'h0;
      wr(OFS_SYSTEM_CONFIGURATION, v);
      `CHK("clock select", v[15:14], inputClockSelect)
      `CHK("clock enables", v[13:10], clkEn)
      `CHK("speed role", v[7:6], {highSpeedEnable, hostRole})
      `CHK("pulls", {v[5], v[5] & ~v[4], v[4]}, pulls)
      `CHK("receiver", v[2] | v[10], fsReceiverOn)
      `CHK("block enable", v[0], blockReset_n)
      rd(OFS_SYSTEM_CONFIGURATION, v & 16'hfff7);
    end
    $display("test config done");
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0005);
    for (int c = 0; c < 4; c++) begin
      @(posedge core_clk);
      lineSet <= c[1:0];
      repeat (4) @(posedge core_clk);
      rd(OFS_SYSTEM_LINE_STATUS, {14'h0000, c[1:0]});
    end
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0001);
    @(posedge core_clk);
    lineSet <= LINE_J;
    repeat (4) @(posedge core_clk);
    rd(OFS_SYSTEM_LINE_STATUS, {14'h0000, LINE_SE1});
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0004);
    repeat (2) @(posedge core_clk);
    rd(OFS_SYSTEM_LINE_STATUS, 16'h0000);
    $display("test line done");
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0081);
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0481);
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0491);
    `CHK("pulls", 3'h1, pulls)
    `CHK("receiver", 1'h1, fsReceiverOn)
    @(posedge core_clk);
    lineSet <= LINE_K;
    repeat (4) @(posedge core_clk);
    rd(OFS_SYSTEM_LINE_STATUS, {14'h0000, LINE_K});
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0081);
    hshake(1'h1);
    `CHK("link speed", 1'h1, linkHighSpeed)
    hshake(1'h0);
    `CHK("link speed", 1'h0, linkHighSpeed)
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0001);
    hshake(1'h1);
    `CHK("full speed only", 1'h0, linkHighSpeed)
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0080);
    hshake(1'h1);
    `CHK("block off speed", 1'h0, linkHighSpeed)
    $display("test speed done");
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0102);
    `CHK("sleep", 1'h1, sleepActive)
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0100);
    `CHK("sleep held", 1'h1, sleepActive)
    rd(OFS_SYSTEM_CONFIGURATION, 16'h0102);
    wake();
    `CHK("sleep exit", 1'h0, sleepActive)
    rd(OFS_SYSTEM_CONFIGURATION, 16'h3d00);
    wr(OFS_SYSTEM_CONFIGURATION, 16'h1c02);
    `CHK("receiver sleep", 1'h0, fsReceiverOn)
    wake();
    rd(OFS_SYSTEM_CONFIGURATION, 16'h2000);
    wr(OFS_SYSTEM_CONFIGURATION, 16'h0100);
    wake();
    rd(OFS_SYSTEM_CONFIGURATION, 16'h3d00);
    $display("test sleep done");
    wr(OFS_SYSTEM_LINE_STATUS, 16'hffff);
    rd(8'h04, 16'h0000);
    rd(OFS_SYSTEM_CONFIGURATION, 16'h3d00);
    repeat (2) @(posedge core_clk);
    $display("test map done");
    close_out();
  end
endmodule
